/* hdl/slr_pkg.sv */
// Shared constants and types for the serial link lane override registers
package slr_pkg;

    // ****************************************************************
    // Register indices (byte address is four times the index)
    // ****************************************************************
    localparam logic [7:0] SLR_IDX_CTRL     = 8'h73;
    localparam logic [7:0] SLR_IDX_SUM_12   = 8'h74;
    localparam logic [7:0] SLR_IDX_SUM_34   = 8'h75;
    localparam logic [7:0] SLR_IDX_IDENT_12 = 8'h76;
    localparam logic [7:0] SLR_IDX_IDENT_34 = 8'h77;
    localparam logic [7:0] SLR_IDX_STAT_ID  = 8'h70;
    localparam logic [7:0] SLR_IDX_STAT_SUM = 8'h71;
    localparam logic [7:0] SLR_IDX_STAT_LNK = 8'h72;

    // ****************************************************************
    // Field positions
    // ****************************************************************
    localparam int SLR_CTRL_IDENT_LSB = 12;
    localparam int SLR_CTRL_SUM_LSB   = 8;
    localparam int SLR_CTRL_UNLOCK    = 4;
    localparam int SLR_HI_LSB         = 8;
    localparam int SLR_LO_LSB         = 0;
    localparam int SLR_LNK_RESV_ERR   = 0;
    localparam int SLR_LNK_MAP_ERR    = 1;
    localparam int SLR_LNK_VER_LSB    = 8;
    localparam int SLR_LNK_SUBCL_LSB  = 12;

    // ****************************************************************
    // Reset values and fixed codes
    // ****************************************************************
    localparam logic [3:0] SLR_RST_FORCE  = 4'h0;
    localparam logic       SLR_RST_UNLOCK = 1'b0;
    localparam logic [7:0] SLR_RST_SUM    = 8'h00;
    localparam logic [4:0] SLR_RST_IDENT  = 5'h00;
    localparam logic [3:0][4:0] SLR_DEF_IDENT = {5'h04, 5'h03, 5'h02, 5'h01};
    localparam logic [2:0] SLR_VER_B      = 3'h1;
    localparam logic [2:0] SLR_SUBCLASS_1 = 3'h1;
    localparam logic [1:0] SLR_HTRANS_NSEQ = 2'h2;
    localparam logic [1:0] SLR_HTRANS_SEQ  = 2'h3;

    // ****************************************************************
    // Types
    // ****************************************************************
    typedef struct packed {
        logic [3:0] ident_force;
        logic [3:0] sum_force;
        logic       version_unlock;
    } slr_ctrl_t;

    typedef struct packed {
        slr_ctrl_t       ctrl;
        logic [3:0][7:0] sum_value;
        logic [3:0][4:0] ident_value;
    } slr_regs_t;

    typedef struct packed {
        logic       valid;
        logic       write;
        logic       mapped;
        logic [7:0] idx;
    } slr_aph_t;

    typedef struct packed {
        logic [2:0] version;
        logic [2:0] subclass;
    } slr_mode_t;

endpackage

/* hdl/slr_lane_sel.sv */
// One lane: registered choice of lane identity and configuration checksum
`timescale 1ns/1ps
module slr_lane_sel
    import slr_pkg::*;
#(
    parameter logic [4:0] DEF_IDENT = 5'h01
) (
    input  wire logic       clock,
    input  wire logic       rst,
    input  wire logic       ident_force,
    input  wire logic [4:0] ident_value,
    input  wire logic       sum_force,
    input  wire logic [7:0] sum_value,
    input  wire logic [7:0] sum_calc,
    output logic      [4:0] ident_q,
    output logic      [7:0] sum_q
);
    logic [4:0] ident_d;
    logic [7:0] sum_d;

    assign ident_d = ident_force ? ident_value : DEF_IDENT; // [RL1] [RL2] [RL3] [RL4]
    assign sum_d   = sum_force ? sum_value : sum_calc;      // [RL5] [RL6] [RL7]

    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            ident_q <= SLR_RST_IDENT;
            sum_q   <= SLR_RST_SUM;
        end else begin
            ident_q <= ident_d;
            sum_q   <= sum_d;
        end
    end
endmodule

/* hdl/slr_ver_sel.sv */
// Registered link version and subclass, locked unless unlocked by software
`timescale 1ns/1ps
module slr_ver_sel
    import slr_pkg::*;
(
    input  wire logic      clock,
    input  wire logic      rst,
    input  wire logic      unlock,
    input  wire slr_mode_t prog,
    output slr_mode_t      mode_q
);
    slr_mode_t mode_d;

    assign mode_d = unlock ? prog : '{version: SLR_VER_B, subclass: SLR_SUBCLASS_1}; // [RL8]

    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            mode_q <= '{version: SLR_VER_B, subclass: SLR_SUBCLASS_1}; // [RL10]
        end else begin
            mode_q <= mode_d;
        end
    end
endmodule

/* hdl/slr_regs.sv */
// Lane override register bank with an AHB-Lite slave port
`timescale 1ns/1ps

// Function
// RL1: Lane 1 sends ID 00001 unless forced, then the programmed upper ID field.
// RL2: Lane 2 sends ID 00010 unless forced, then the programmed lower ID field.
// RL3: Lane 3 sends ID 00011 unless forced, then the programmed upper ID field.
// RL4: Lane 4 sends ID 00100 unless forced, then the programmed lower ID field.
// RL5: Without its checksum force bit, each lane sends the checksum it computes.
// RL6: Forced lanes 1 and 2 send the programmed upper and lower checksum bytes.
// RL7: Forced lanes 3 and 4 send the programmed upper and lower checksum bytes.
// RL8: Version locked to B subclass 1 unless unlocked; then programmed settings apply.
// RL9: Software writes zeros to all reserved bit positions.
// RL10: Every field clears to zero on reset; link version and subclass reset to B and 1 instead.
module slr_regs
    import slr_pkg::*;
#(
    parameter int ADDR_W = 12
) (
    input  wire logic                  clock,
    input  wire logic                  rst,
    input  wire logic                  hsel,
    input  wire logic [ADDR_W-1:0]     haddr,
    input  wire logic [1:0]            htrans,
    input  wire logic                  hwrite,
    input  wire logic [2:0]            hsize,
    input  wire logic [31:0]           hwdata,
    input  wire logic                  hready,
    output logic      [31:0]           hrdata,
    output logic                       hreadyout,
    output logic                       hresp,
    input  wire logic [3:0][7:0]       lane_cfg_sum_calc,
    input  wire slr_mode_t             prog_mode,
    output logic      [3:0][4:0]       lane_ident,
    output logic      [3:0][7:0]       lane_cfg_sum,
    output slr_mode_t                  link_mode
);

    // ****************************************************************
    // Elaboration check
    // ****************************************************************
    if (ADDR_W < 10 || ADDR_W > 32) begin : g_bad_addr_w
        $error("ADDR_W must lie between 10 and 32");
    end

    // ****************************************************************
    // Functions
    // ****************************************************************
    // Control bit order on the bus runs lane 1 at the top
    function automatic logic [3:0] rev4(input logic [3:0] v);
        rev4 = {v[0], v[1], v[2], v[3]};
    endfunction

    function automatic logic [4:0] ident_field(input logic [31:0] w, input int lsb);
        ident_field = w[lsb +: 5];
    endfunction

    function automatic logic [7:0] sum_field(input logic [31:0] w, input int lsb);
        sum_field = w[lsb +: 8];
    endfunction

    function automatic logic is_mapped(input logic [7:0] idx);
        is_mapped = (idx >= SLR_IDX_STAT_ID) && (idx <= SLR_IDX_IDENT_34);
    endfunction

    // ****************************************************************
    // Declarations
    // ****************************************************************
    slr_regs_t  regs_q;
    slr_regs_t  regs_d;
    slr_aph_t   aph_q;
    slr_aph_t   aph_d;
    logic [31:0] rdata_q;
    logic [31:0] rdata_d;
    logic        resv_err_q;
    logic        resv_err_d;
    logic        map_err_q;
    logic        map_err_d;
    slr_mode_t   mode_q;
    logic [3:0][4:0] ident_q;
    logic [3:0][7:0] sum_q;

    logic                  take;
    logic [ADDR_W-3:0]     addr_word;
    logic                  addr_in_range;
    logic [7:0]            addr_idx;
    logic                  wr;
    logic                  wr_ctrl;
    logic                  wr_sum12;
    logic                  wr_sum34;
    logic                  wr_id12;
    logic                  wr_id34;
    logic                  wr_lnk;
    logic                  resv_hit;
    logic                  map_hit;

    logic [31:0] word_ctrl;
    logic [31:0] word_sum12;
    logic [31:0] word_sum34;
    logic [31:0] word_id12;
    logic [31:0] word_id34;
    logic [31:0] word_stat_id;
    logic [31:0] word_stat_sum;
    logic [31:0] word_stat_lnk;

    // ****************************************************************
    // Address phase
    // ****************************************************************
    assign take = hsel && hready && (htrans == SLR_HTRANS_NSEQ || htrans == SLR_HTRANS_SEQ);
    assign addr_word = haddr[ADDR_W-1:2];
    assign addr_in_range = (addr_word >> 8) == '0;
    assign addr_idx = addr_word[7:0];

    assign aph_d.valid  = take;
    assign aph_d.write  = hwrite;
    assign aph_d.mapped = addr_in_range && is_mapped(addr_idx);
    assign aph_d.idx    = addr_idx;

    // ****************************************************************
    // Data phase write decode
    // ****************************************************************
    assign wr       = aph_q.valid && aph_q.write && aph_q.mapped;
    assign wr_ctrl  = wr && (aph_q.idx == SLR_IDX_CTRL);
    assign wr_sum12 = wr && (aph_q.idx == SLR_IDX_SUM_12);
    assign wr_sum34 = wr && (aph_q.idx == SLR_IDX_SUM_34);
    assign wr_id12  = wr && (aph_q.idx == SLR_IDX_IDENT_12);
    assign wr_id34  = wr && (aph_q.idx == SLR_IDX_IDENT_34);
    assign wr_lnk   = wr && (aph_q.idx == SLR_IDX_STAT_LNK);

    // Reserved bits are never stored; a nonzero write is only flagged
    assign resv_hit = (wr && (|hwdata[31:16]))                                       // [RL9]
                   || (wr_ctrl && ((|hwdata[7:5]) || (|hwdata[3:0])))                // [RL9]
                   || ((wr_id12 || wr_id34) && ((|hwdata[15:13]) || (|hwdata[7:5]))); // [RL9]
    assign map_hit  = aph_q.valid && !aph_q.mapped;

    // ****************************************************************
    // Register next values
    // ****************************************************************
    assign regs_d.ctrl.ident_force = wr_ctrl
        ? rev4(hwdata[SLR_CTRL_IDENT_LSB +: 4]) : regs_q.ctrl.ident_force;
    assign regs_d.ctrl.sum_force = wr_ctrl
        ? rev4(hwdata[SLR_CTRL_SUM_LSB +: 4]) : regs_q.ctrl.sum_force;
    assign regs_d.ctrl.version_unlock = wr_ctrl
        ? hwdata[SLR_CTRL_UNLOCK] : regs_q.ctrl.version_unlock;

    assign regs_d.sum_value[0] = wr_sum12
        ? sum_field(hwdata, SLR_HI_LSB) : regs_q.sum_value[0]; // [RL6]
    assign regs_d.sum_value[1] = wr_sum12
        ? sum_field(hwdata, SLR_LO_LSB) : regs_q.sum_value[1]; // [RL6]
    assign regs_d.sum_value[2] = wr_sum34
        ? sum_field(hwdata, SLR_HI_LSB) : regs_q.sum_value[2]; // [RL7]
    assign regs_d.sum_value[3] = wr_sum34
        ? sum_field(hwdata, SLR_LO_LSB) : regs_q.sum_value[3]; // [RL7]

    assign regs_d.ident_value[0] = wr_id12
        ? ident_field(hwdata, SLR_HI_LSB) : regs_q.ident_value[0]; // [RL1]
    assign regs_d.ident_value[1] = wr_id12
        ? ident_field(hwdata, SLR_LO_LSB) : regs_q.ident_value[1]; // [RL2]
    assign regs_d.ident_value[2] = wr_id34
        ? ident_field(hwdata, SLR_HI_LSB) : regs_q.ident_value[2]; // [RL3]
    assign regs_d.ident_value[3] = wr_id34
        ? ident_field(hwdata, SLR_LO_LSB) : regs_q.ident_value[3]; // [RL4]

    // Sticky error flags: writing 1 clears, a new event in the same cycle wins
    assign resv_err_d = resv_hit
        || (resv_err_q && !(wr_lnk && hwdata[SLR_LNK_RESV_ERR]));
    assign map_err_d  = map_hit
        || (map_err_q && !(wr_lnk && hwdata[SLR_LNK_MAP_ERR]));

    // ****************************************************************
    // Read words; the writable ones are built from next values so a read right after a write
    // returns the new contents, the lane status words from the registered lane outputs
    // ****************************************************************
    assign word_ctrl = {16'h0000,
                        rev4(regs_d.ctrl.ident_force),
                        rev4(regs_d.ctrl.sum_force),
                        3'h0,
                        regs_d.ctrl.version_unlock,
                        4'h0};
    assign word_sum12 = {16'h0000, regs_d.sum_value[0], regs_d.sum_value[1]};
    assign word_sum34 = {16'h0000, regs_d.sum_value[2], regs_d.sum_value[3]};
    assign word_id12  = {16'h0000,
                         3'h0, regs_d.ident_value[0],
                         3'h0, regs_d.ident_value[1]};
    assign word_id34  = {16'h0000,
                         3'h0, regs_d.ident_value[2],
                         3'h0, regs_d.ident_value[3]};
    assign word_stat_id  = {12'h000, ident_q[3], ident_q[2], ident_q[1], ident_q[0]};
    assign word_stat_sum = {sum_q[3], sum_q[2], sum_q[1], sum_q[0]};
    assign word_stat_lnk = {17'h00000,
                            mode_q.subclass,
                            1'b0,
                            mode_q.version,
                            6'h00,
                            map_err_d,
                            resv_err_d};

    always_comb begin
        rdata_d = 32'h0000_0000;
        if (!aph_d.valid || aph_d.write || !aph_d.mapped) begin
            rdata_d = 32'h0000_0000;
        end else if (aph_d.idx == SLR_IDX_CTRL) begin
            rdata_d = word_ctrl;
        end else if (aph_d.idx == SLR_IDX_SUM_12) begin
            rdata_d = word_sum12;
        end else if (aph_d.idx == SLR_IDX_SUM_34) begin
            rdata_d = word_sum34;
        end else if (aph_d.idx == SLR_IDX_IDENT_12) begin
            rdata_d = word_id12;
        end else if (aph_d.idx == SLR_IDX_IDENT_34) begin
            rdata_d = word_id34;
        end else if (aph_d.idx == SLR_IDX_STAT_ID) begin
            rdata_d = word_stat_id;
        end else if (aph_d.idx == SLR_IDX_STAT_SUM) begin
            rdata_d = word_stat_sum;
        end else if (aph_d.idx == SLR_IDX_STAT_LNK) begin
            rdata_d = word_stat_lnk;
        end
    end

    // ****************************************************************
    // Registers
    // ****************************************************************
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            regs_q.ctrl.ident_force    <= SLR_RST_FORCE;  // [RL10]
            regs_q.ctrl.sum_force      <= SLR_RST_FORCE;  // [RL10]
            regs_q.ctrl.version_unlock <= SLR_RST_UNLOCK; // [RL10]
            regs_q.sum_value           <= {4{SLR_RST_SUM}};   // [RL10]
            regs_q.ident_value         <= {4{SLR_RST_IDENT}}; // [RL10]
        end else begin
            regs_q <= regs_d;
        end
    end

    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            aph_q      <= '0;
            rdata_q    <= 32'h0000_0000;
            resv_err_q <= 1'b0;
            map_err_q  <= 1'b0;
        end else begin
            aph_q      <= aph_d;
            rdata_q    <= rdata_d;
            resv_err_q <= resv_err_d;
            map_err_q  <= map_err_d;
        end
    end

    // Zero wait states and an OKAY response on every transfer
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            hreadyout <= 1'b1;
            hresp     <= 1'b0;
        end else begin
            hreadyout <= 1'b1;
            hresp     <= 1'b0;
        end
    end

    assign hrdata = rdata_q;

    // ****************************************************************
    // Lane selectors
    // ****************************************************************
    for (genvar i = 0; i < 4; i++) begin : g_lane
        slr_lane_sel #(
            .DEF_IDENT(SLR_DEF_IDENT[i])
        ) u_lane (
            .clock      (clock),
            .rst        (rst),
            .ident_force(regs_q.ctrl.ident_force[i]),  // [RL1] [RL2] [RL3] [RL4]
            .ident_value(regs_q.ident_value[i]),
            .sum_force  (regs_q.ctrl.sum_force[i]),    // [RL5]
            .sum_value  (regs_q.sum_value[i]),
            .sum_calc   (lane_cfg_sum_calc[i]),        // [RL5]
            .ident_q    (ident_q[i]),
            .sum_q      (sum_q[i])
        );
    end

    assign lane_ident   = ident_q;
    assign lane_cfg_sum = sum_q;

    // ****************************************************************
    // Link version and subclass
    // ****************************************************************
    slr_ver_sel u_ver (
        .clock (clock),
        .rst   (rst),
        .unlock(regs_q.ctrl.version_unlock), // [RL8]
        .prog  (prog_mode),
        .mode_q(mode_q)
    );

    assign link_mode = mode_q;

endmodule

/* sim/slr_regs_sva.sv */
// Checker for the lane override register bank, bound to its top module
`timescale 1ns/1ps
module slr_regs_sva
    import slr_pkg::*;
#(
    parameter int ADDR_W = 12
) (
    input wire logic                  clock,
    input wire logic                  rst,
    input wire logic                  hsel,
    input wire logic [ADDR_W-1:0]     haddr,
    input wire logic [1:0]            htrans,
    input wire logic                  hwrite,
    input wire logic [2:0]            hsize,
    input wire logic [31:0]           hwdata,
    input wire logic                  hready,
    input wire logic [31:0]           hrdata,
    input wire logic                  hreadyout,
    input wire logic                  hresp,
    input wire logic [3:0][7:0]       lane_cfg_sum_calc,
    input wire slr_mode_t             prog_mode,
    input wire logic [3:0][4:0]       lane_ident,
    input wire logic [3:0][7:0]       lane_cfg_sum,
    input wire slr_mode_t             link_mode
);
    // ****************************************************************
    // Shadow of the stored fields, kept from observed writes
    // ****************************************************************
    localparam logic [4:0][15:0] MSK = {16'h1f1f, 16'h1f1f, 16'hffff, 16'hffff, 16'hff10};
    localparam slr_mode_t        LOCKED = slr_mode_t'({SLR_VER_B, SLR_SUBCLASS_1});
    logic              ap_v_q;
    logic              ap_w_q;
    logic [ADDR_W-3:0] ap_i_q;
    logic [4:0][15:0]  sh_q;
    logic              ap_map;
    logic [2:0]        ap_k;
    assign ap_map = ap_i_q >= (ADDR_W-2)'(SLR_IDX_CTRL) && ap_i_q <= (ADDR_W-2)'(SLR_IDX_IDENT_34);
    assign ap_k   = ap_i_q[2:0] - 3'h3;
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            ap_v_q <= 1'b0;
            ap_w_q <= 1'b0;
            ap_i_q <= '0;
            sh_q   <= '0;
        end else begin
            ap_v_q <= hsel && hready && htrans[1];
            ap_w_q <= hwrite;
            ap_i_q <= haddr[ADDR_W-1:2];
            if (ap_v_q && ap_w_q && ap_map) begin
                sh_q[ap_k] <= hwdata[15:0] & MSK[ap_k];
            end
        end
    end
    // ****************************************************************
    // Assertions
    // ****************************************************************
    default clocking cb @(posedge clock); endclocking
    default disable iff (rst);
    sequence s_map_read;
        ap_v_q && !ap_w_q && ap_map;
    endsequence
    a_lane1_ident: assert property (
        !$past(rst) |-> lane_ident[0] == $past(sh_q[0][15] ? sh_q[3][12:8] : 5'h01))
        else $error("lane 1 identity wrong");
    a_lane2_ident: assert property (
        !$past(rst) |-> lane_ident[1] == $past(sh_q[0][14] ? sh_q[3][4:0] : 5'h02))
        else $error("lane 2 identity wrong");
    a_lane3_ident: assert property (
        !$past(rst) |-> lane_ident[2] == $past(sh_q[0][13] ? sh_q[4][12:8] : 5'h03))
        else $error("lane 3 identity wrong");
    a_lane4_ident: assert property (
        !$past(rst) |-> lane_ident[3] == $past(sh_q[0][12] ? sh_q[4][4:0] : 5'h04))
        else $error("lane 4 identity wrong");
    a_low_lane_sums: assert property (
        !$past(rst) |-> lane_cfg_sum[0] == $past(sh_q[0][11] ? sh_q[1][15:8] : lane_cfg_sum_calc[0])
        && lane_cfg_sum[1] == $past(sh_q[0][10] ? sh_q[1][7:0] : lane_cfg_sum_calc[1]))
        else $error("lane 1 or 2 checksum wrong");
    a_high_lane_sums: assert property (
        !$past(rst) |-> lane_cfg_sum[2] == $past(sh_q[0][9] ? sh_q[2][15:8] : lane_cfg_sum_calc[2])
        && lane_cfg_sum[3] == $past(sh_q[0][8] ? sh_q[2][7:0] : lane_cfg_sum_calc[3]))
        else $error("lane 3 or 4 checksum wrong");
    a_mode_lock: assert property (
        !$past(rst) |-> link_mode == $past(sh_q[0][4] ? prog_mode : LOCKED))
        else $error("link mode wrong");
    a_reset_clear: assert property (disable iff (1'b0)
        rst |-> lane_ident == '0 && lane_cfg_sum == '0 && hrdata == '0 && link_mode == LOCKED)
        else $error("outputs not cleared in reset");
    a_read_back: assert property (
        s_map_read |-> hrdata == {16'h0000, sh_q[ap_k]})
        else $error("register read back wrong");
endmodule

bind slr_regs slr_regs_sva #(.ADDR_W(ADDR_W)) u_sva (
    .clock(clock), .rst(rst), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
    .hsize(hsize), .hwdata(hwdata), .hready(hready), .hrdata(hrdata), .hreadyout(hreadyout),
    .hresp(hresp), .lane_cfg_sum_calc(lane_cfg_sum_calc), .prog_mode(prog_mode),
    .lane_ident(lane_ident), .lane_cfg_sum(lane_cfg_sum), .link_mode(link_mode));

/* sim/slr_link_far.sv */
// Far-side model: link logic supplying computed checksums and programmed mode
`timescale 1ns/1ps
module slr_link_far
    import slr_pkg::*;
(
    input  wire logic       clock,
    input  wire logic       rst,
    output logic [3:0][7:0] sum_calc,
    output slr_mode_t       mode
);
    // ****************************************************************
    // Values change every cycle so a stale capture shows up
    // ****************************************************************
    logic [31:0] lfsr_q;
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            lfsr_q <= 32'h0000_0001;
        end else begin
            lfsr_q <= {lfsr_q[30:0], lfsr_q[31] ^ lfsr_q[21] ^ lfsr_q[1] ^ lfsr_q[0]};
        end
    end
    assign sum_calc = lfsr_q;
    assign mode     = slr_mode_t'(lfsr_q[13:8]);
endmodule

/* sim/serial_link_lane_override_regs_tb_top.sv */
// Self-checking bench for the lane override register bank
`timescale 1ns/1ps
module serial_link_lane_override_regs_tb_top;
    import slr_pkg::*;
    logic                clock, rst, hsel, hwrite, hready, hreadyout, hresp;
    logic [11:0]         haddr;
    logic [1:0]          htrans;
    logic [2:0]          hsize;
    logic [31:0]         hwdata, hrdata, r;
    logic [3:0][7:0]     sum_calc, lane_cfg_sum, calc_p;
    logic [3:0][4:0]     lane_ident;
    slr_mode_t           prog_mode, link_mode, mode_p;
    logic [4:0][15:0]    sh;
    int                  bad_count, tests_run, cyc, k;
    integer              seed;
    assign hready = hreadyout;
    always #50 clock = ~clock;
    always @(posedge clock) begin
        calc_p <= sum_calc;
        mode_p <= prog_mode;
        cyc    <= cyc + 1;
        if (cyc == 20000) begin
            bad_count++;
            test_done();
        end
    end
    slr_regs dut (.clock(clock), .rst(rst), .hsel(hsel), .haddr(haddr), .htrans(htrans),
        .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready), .hrdata(hrdata),
        .hreadyout(hreadyout), .hresp(hresp), .lane_cfg_sum_calc(sum_calc),
        .prog_mode(prog_mode), .lane_ident(lane_ident), .lane_cfg_sum(lane_cfg_sum),
        .link_mode(link_mode));
    slr_link_far far (.clock(clock), .rst(rst), .sum_calc(sum_calc), .mode(prog_mode));
    // ****************************************************************
    // Expectation functions and bus tasks
    // ****************************************************************
    function automatic logic [15:0] msk(int i);
        return (i == 0) ? 16'hff10 : (i < 3) ? 16'hffff : 16'h1f1f;
    endfunction
    function automatic logic [4:0] exp_id(int i);
        logic [15:0] v;
        v = sh[3 + i / 2] >> ((i % 2 == 0) ? 8 : 0);
        return sh[0][15 - i] ? v[4:0] : 5'(i + 1);
    endfunction
    function automatic logic [7:0] exp_sum(int i);
        logic [15:0] v;
        v = sh[1 + i / 2] >> ((i % 2 == 0) ? 8 : 0);
        return sh[0][11 - i] ? v[7:0] : calc_p[i];
    endfunction
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        tests_run++;
        if (got !== exp) begin
            bad_count++;
            $display("[FAIL] %0t got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic xfer(input logic w, input logic [9:0] idx, input logic [31:0] wd);
        @(posedge clock);
        hsel   <= 1'b1;
        htrans <= SLR_HTRANS_NSEQ;
        hwrite <= w;
        haddr  <= {idx, 2'h0};
        do begin @(posedge clock); end while (hready !== 1'b1);
        htrans <= 2'h0;
        hwdata <= wd;
        do begin @(posedge clock); end while (hready !== 1'b1);
        r = hrdata;
    endtask
    task automatic wr(input int i, input logic [31:0] d);
        xfer(1'b1, 10'(SLR_IDX_CTRL) + 10'(i), d);
        sh[i] = d[15:0] & msk(i);
    endtask
    task automatic rd_all;
        for (int i = 0; i < 5; i++) begin
            xfer(1'b0, 10'(SLR_IDX_CTRL) + 10'(i), 32'h0);
            chk(r, {16'h0000, sh[i]});
        end
    endtask
    task automatic chk_lanes;
        @(posedge clock);
        @(negedge clock);
        for (int i = 0; i < 4; i++) begin
            chk(32'(lane_ident[i]), 32'(exp_id(i)));
            chk(32'(lane_cfg_sum[i]), 32'(exp_sum(i)));
        end
        chk(32'(link_mode), 32'(sh[0][4] ? mode_p : {SLR_VER_B, SLR_SUBCLASS_1}));
    endtask
    task automatic do_reset(input int n);
        rst <= 1'b1;
        sh = '0;
        repeat (n) @(posedge clock);
        @(negedge clock);
        chk(32'(lane_ident), 32'h0);
        chk(lane_cfg_sum, 32'h0);
        chk({24'h0, hreadyout, hresp, link_mode}, {26'h002, SLR_VER_B, SLR_SUBCLASS_1});
        @(posedge clock);
        rst <= 1'b0;
        chk_lanes();
    endtask
    task automatic test_done;
        $display("comparisons %0d mismatches %0d", tests_run, bad_count);
        if (bad_count == 0 && tests_run > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask
    // ****************************************************************
    // Main sequence
    // ****************************************************************
    initial begin
        clock = 1'b0; rst = 1'b0; hsel = 1'b0; haddr = '0; htrans = 2'h0; hwrite = 1'b0;
        hsize = 3'h2; hwdata = '0; sh = '0; bad_count = 0; tests_run = 0; cyc = 0;
        seed = 32'h4d19;
        do_reset(16);
        rd_all();
        for (int i = 4; i >= 0; i--) begin
            wr(i, 32'hffff_ffff);
        end
        chk_lanes();
        rd_all();
        wr(0, 32'h0000_0000);
        chk_lanes();
        repeat (60) begin
            k = $unsigned($random(seed)) % 5;
            wr(k, $random(seed) & {16'h0000, msk(k)});
            chk_lanes();
            rd_all();
        end
        xfer(1'b1, 10'h373, 32'h0000_ffff);
        xfer(1'b1, 10'h078, 32'h0000_ffff);
        xfer(1'b0, 10'h373, 32'h0);
        chk(r, 32'h0);
        rd_all();
        wr(0, 32'h0000_ff10);
        chk_lanes();
        @(posedge clock);
        do_reset(2);
        rd_all();
        test_done();
    end
endmodule
